// File: core/adi_axis_drive.sv
// One axis of the drive signal interface: absolute transfer, servo on,
// handwheel decode, zero marker and differential pulse outputs
`timescale 1ns/1ps
module adi_axis_drive
    import adi_pkg::*;
#(
    parameter int ABS_TIMEOUT = ABS_TIMEOUT_CYC
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    // Drive unit, absolute transfer and servo power on
    input  wire logic                  absolute_data_ready,
    input  wire logic                  absolute_data_lsb,
    input  wire logic                  absolute_data_msb,
    output logic                       absolute_transfer_mode,
    output logic                       absolute_position_request,
    output logic                       servo_power_on,
    // Handwheel, negative logic
    input  wire logic                  handwheel_phase_a_neg,
    input  wire logic                  handwheel_phase_b_neg,
    // Zero marker
    input  wire logic                  zero_marker_input,
    // Differential pulse outputs
    output adi_diff_t                  pulse_out,
    output adi_diff_t                  pulse_sign,
    // User side
    input  wire logic                  servo_on_cmd,
    input  wire logic                  abs_start,
    output logic                       abs_busy,
    output logic                       abs_done,
    output logic                       abs_error,
    output logic [ABS_WORD_W-1:0]      abs_position,
    input  wire logic                  handwheel_enable,
    input  wire logic                  address_load,
    input  wire logic [ADDR_W-1:0]     address_load_value,
    output logic [ADDR_W-1:0]          positioning_address,
    input  wire logic                  zero_return_active,
    input  wire logic                  stopper_method,
    output logic                       zero_marker_event,
    output logic                       zero_return_done,
    input  wire logic                  pulse_req,
    input  wire logic                  pulse_dir_neg,
    output logic                       pulse_ready
);

    // ******************************************************************
    // Reset release and input synchronisation
    // ******************************************************************
    logic    rst_sync_b;
    adi_in_t raw_in;
    adi_in_t sin;

    adi_sync #(.WIDTH(1)) u_rst_sync
    (
        .clk   (sys_clk),
        .rst_n (rst_b),
        .d     (1'b1),
        .q     (rst_sync_b)
    );

    // Handwheel pins are negative logic, made active high here
    assign raw_in = '{data_ready  : absolute_data_ready,
                      data_lsb    : absolute_data_lsb,
                      data_msb    : absolute_data_msb,
                      phase_a     : ~handwheel_phase_a_neg,
                      phase_b     : ~handwheel_phase_b_neg,
                      zero_marker : zero_marker_input};

    adi_sync #(.WIDTH(IN_W)) u_in_sync
    (
        .clk   (sys_clk),
        .rst_n (rst_sync_b),
        .d     (raw_in),
        .q     (sin)   // RQ14
    );

    // ******************************************************************
    // Quadrature step decode
    // ******************************************************************
    function automatic adi_quad_t quad_step(input logic [1:0] prev,
                                            input logic [1:0] cur);
        adi_quad_t r;
        r = QD_NONE;
        unique case ({prev, cur})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: r = QD_INC;
            4'b0001, 4'b0111, 4'b1110, 4'b1000: r = QD_DEC;
            default:                            r = QD_NONE;
        endcase
        return r;
    endfunction

    // ******************************************************************
    // Servo power on
    // ******************************************************************
    logic servo_on_q;

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            servo_on_q <= 1'b0;
        else
            servo_on_q <= servo_on_cmd; // RQ7
    end

    assign servo_power_on = servo_on_q;

    // ******************************************************************
    // Absolute position transfer
    // ******************************************************************
    adi_abs_state_t          abs_st_q;
    adi_abs_state_t          abs_st_d;
    logic [TMR_W-1:0]        tmr_q;
    logic [TMR_W-1:0]        tmr_d;
    logic [STEP_W-1:0]       step_q;
    logic [STEP_W-1:0]       step_d;
    logic [ABS_WORD_W-1:0]   word_q;
    logic [ABS_WORD_W-1:0]   word_d;
    logic [ABS_WORD_W-1:0]   abs_pos_q;
    logic                    err_q;
    logic                    err_d;
    logic                    mode_on;
    logic                    ready_ok;
    logic [1:0]              pair;
    logic                    timed_out;
    logic                    setup_over;

    // Ready only counts while the mode is on
    assign mode_on    = (abs_st_q != AB_IDLE);            // RQ1
    assign ready_ok   = mode_on & sin.data_ready;         // RQ2
    assign pair       = {sin.data_msb, sin.data_lsb};     // RQ5
    assign timed_out  = (tmr_q == TMR_W'(ABS_TIMEOUT - 1));
    assign setup_over = (tmr_q == TMR_W'(MODE_SETUP_CYC - 1));

    // Next state: one pair per request, ready must fall before the next
    always_comb
    begin
        abs_st_d = abs_st_q;
        tmr_d    = tmr_q + 1'b1;
        step_d   = step_q;
        word_d   = word_q;
        err_d    = 1'b0;
        unique case (abs_st_q)
            AB_IDLE:
            begin
                tmr_d  = '0;
                step_d = '0;
                if (abs_start)
                    abs_st_d = AB_SETUP;                  // RQ6
            end
            AB_SETUP:
            begin
                if (setup_over)
                begin
                    abs_st_d = AB_REQ;
                    tmr_d    = '0;
                end
            end
            AB_REQ:
            begin
                if (ready_ok)
                begin
                    // First pair ends in the low bits
                    word_d   = {pair, word_q[ABS_WORD_W-1:2]}; // RQ6
                    abs_st_d = AB_REL;
                    tmr_d    = '0;
                end
                else if (timed_out)
                begin
                    err_d    = 1'b1;
                    abs_st_d = AB_IDLE;
                end
            end
            AB_REL:
            begin
                if (!ready_ok)
                begin
                    tmr_d  = '0;
                    step_d = step_q + 1'b1;
                    if (step_q == LAST_STEP)
                        abs_st_d = AB_DONE;
                    else
                        abs_st_d = AB_REQ;
                end
                else if (timed_out)
                begin
                    err_d    = 1'b1;
                    abs_st_d = AB_IDLE;
                end
            end
            AB_DONE:
            begin
                abs_st_d = AB_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            abs_st_q <= AB_IDLE;
            tmr_q    <= '0;
            step_q   <= '0;
            word_q   <= ABS_WORD_RST;
            err_q    <= 1'b0;
        end
        else
        begin
            abs_st_q <= abs_st_d;
            tmr_q    <= tmr_d;
            step_q   <= step_d;
            word_q   <= word_d;
            err_q    <= err_d;
        end
    end

    // Result word is published only when every pair is in
    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            abs_pos_q <= ABS_WORD_RST;
        else if (abs_st_q == AB_DONE)
            abs_pos_q <= word_q;
    end

    assign absolute_transfer_mode    = mode_on;                 // RQ1
    assign absolute_position_request = (abs_st_q == AB_REQ);    // RQ3
    assign abs_busy                  = mode_on;
    assign abs_done                  = (abs_st_q == AB_DONE);
    assign abs_error                 = err_q;
    assign abs_position              = abs_pos_q;

    // ******************************************************************
    // Handwheel position counter
    // ******************************************************************
    logic [1:0]        phase_prev_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    adi_quad_t         qstep;

    assign qstep = quad_step(phase_prev_q, {sin.phase_a, sin.phase_b});

    // Every edge of either phase moves the address by one; a skipped
    // state (both phases changed) is dropped rather than guessed
    always_comb
    begin
        addr_d = addr_q;
        if (address_load)
            addr_d = address_load_value;
        else if (handwheel_enable && qstep == QD_INC)
            addr_d = addr_q + 1'b1;                          // RQ8
        else if (handwheel_enable && qstep == QD_DEC)
            addr_d = addr_q - 1'b1;                          // RQ9
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            phase_prev_q <= 2'h0;
            addr_q       <= ADDR_RST;
        end
        else
        begin
            phase_prev_q <= {sin.phase_a, sin.phase_b};
            addr_q       <= addr_d;
        end
    end

    assign positioning_address = addr_q;

    // ******************************************************************
    // Zero marker detection
    // ******************************************************************
    logic zero_prev_q;
    logic zero_evt_q;
    logic zero_done_q;
    logic zero_rise;

    // Steady high level never repeats the event
    assign zero_rise = sin.zero_marker & ~zero_prev_q;      // RQ11

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            zero_prev_q <= 1'b0;
            zero_evt_q  <= 1'b0;
            zero_done_q <= 1'b0;
        end
        else
        begin
            zero_prev_q <= sin.zero_marker;
            zero_evt_q  <= zero_rise;                                 // RQ10
            zero_done_q <= zero_rise & zero_return_active
                           & stopper_method;                  // RQ12
        end
    end

    assign zero_marker_event = zero_evt_q;
    assign zero_return_done  = zero_done_q;

    // ******************************************************************
    // Differential pulse and sign outputs
    // ******************************************************************
    logic [TMR_W-1:0] pw_q;
    logic             pulse_q;
    logic             sign_q;
    logic             busy_q;
    logic             pw_end;

    assign pw_end      = (pw_q == TMR_W'(PULSE_WIDTH_CYC - 1));
    assign pulse_ready = ~busy_q;

    // High phase then low phase; sign is held for the whole pulse
    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pw_q    <= '0;
            pulse_q <= 1'b0;
            sign_q  <= 1'b0;
            busy_q  <= 1'b0;
        end
        else if (!busy_q)
        begin
            pw_q <= '0;
            if (pulse_req)
            begin
                busy_q  <= 1'b1;
                pulse_q <= 1'b1;
                sign_q  <= pulse_dir_neg;
            end
        end
        else if (pw_end)
        begin
            pw_q    <= '0;
            pulse_q <= 1'b0;
            busy_q  <= pulse_q;
        end
        else
            pw_q <= pw_q + 1'b1;
    end

    // Complementary pairs for a line receiver
    assign pulse_out  = '{pos: pulse_q, neg: ~pulse_q};     // RQ13
    assign pulse_sign = '{pos: sign_q,  neg: ~sign_q};      // RQ13

endmodule

// File: core/adi_pkg.sv
// Constants and carrier types for the axis drive signal interface
//
// Contract
// [RQ1] A transfer-mode output selects absolute transfer, and only then are data-ready and both data bits taken as valid.
// [RQ2] Data-ready and both data bits are ignored whenever transfer mode is off.
// [RQ3] The position request output is driven only while transfer mode is selected.
// [RQ4] The drive raises data-ready when a bit pair is present on the data inputs during transfer mode.
// [RQ5] Each step carries two bits, the lsb input as bit 0 and the msb input as bit 1 of the pair.
// [RQ6] A transfer runs mode on, request on, wait for ready, capture both bits, request off, and repeats until all bits are in.
// [RQ7] A servo power-on output energises the drive's base circuit.
// [RQ8] With phase A leading B the address rises by one on every edge of either phase.
// [RQ9] With phase B leading A the address falls by one on every edge of either phase.
// [RQ10] The zero marker input is the reference event for machine zero return.
// [RQ11] The zero marker counts only on its off-to-on transition, never on a steady level.
// [RQ12] In stopper-stop return the zero marker event reports that zero return is complete.
// [RQ13] Positioning pulse and pulse sign leave on complementary differential pairs.
// [RQ14] Handwheel phases, zero marker, data-ready and both data bits are synchronised before use.
package adi_pkg;

    // ******************************************************************
    // Clock and timing
    // ******************************************************************
    localparam int CLK_PERIOD_PS     = 5000;
    // Least high and low time of one output pulse
    localparam int PULSE_WIDTH_NS    = 1000;
    localparam int PULSE_WIDTH_CYC   =
        (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Least settle time between mode on and the first request
    localparam int MODE_SETUP_NS     = 10000;
    localparam int MODE_SETUP_CYC    =
        (MODE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Longest wait for one handshake edge from the drive
    localparam int ABS_TIMEOUT_US    = 1000;
    localparam int ABS_TIMEOUT_CYC   =
        (ABS_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
    localparam int TMR_W             = 18;

    // ******************************************************************
    // Widths
    // ******************************************************************
    localparam int ABS_WORD_W        = 32;
    localparam int ABS_STEPS         = ABS_WORD_W / 2;
    localparam int STEP_W            = 5;
    localparam int ADDR_W            = 32;
    localparam logic [STEP_W-1:0] LAST_STEP = 5'h0F;
    localparam logic [ABS_WORD_W-1:0] ABS_WORD_RST = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

    // ******************************************************************
    // Carrier types
    // ******************************************************************
    // Raw drive-side inputs, all active high after inversion
    typedef struct packed {
        logic data_ready;
        logic data_lsb;
        logic data_msb;
        logic phase_a;
        logic phase_b;
        logic zero_marker;
    } adi_in_t;
    localparam int IN_W = 6;

    // One complementary output pair
    typedef struct packed {
        logic pos;
        logic neg;
    } adi_diff_t;

    // Quadrature step result
    typedef enum logic [1:0] {
        QD_NONE = 2'h0,
        QD_INC  = 2'h1,
        QD_DEC  = 2'h3
    } adi_quad_t;

    // Absolute transfer states, Gray along the usual path up to done
    typedef enum logic [2:0] {
        AB_IDLE  = 3'h0,
        AB_SETUP = 3'h1,
        AB_REQ   = 3'h3,
        AB_REL   = 3'h2,
        AB_DONE  = 3'h6
    } adi_abs_state_t;

endpackage

// File: core/adi_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ps
module adi_sync
    import adi_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ******************************************************************
    // First stage feeds only the second stage
    // ******************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

// File: verification/adi_axis_monitor.sv
// Port-level checker for the axis drive signal interface
`timescale 1ns/1ps
module adi_axis_monitor
    import adi_pkg::*;
#(
    parameter int ABS_TIMEOUT = 50
)
(
    input wire logic              sys_clk,
    input wire logic              rst_b,
    input wire logic              absolute_data_ready,
    input wire logic              absolute_transfer_mode,
    input wire logic              absolute_position_request,
    input wire logic              servo_on_cmd,
    input wire logic              servo_power_on,
    input wire logic              abs_start,
    input wire logic              abs_busy,
    input wire logic              abs_done,
    input wire logic              abs_error,
    input wire logic              address_load,
    input wire logic [ADDR_W-1:0] positioning_address,
    input wire logic              zero_marker_input,
    input wire logic              zero_return_active,
    input wire logic              stopper_method,
    input wire logic              zero_marker_event,
    input wire logic              zero_return_done,
    input wire adi_diff_t         pulse_out,
    input wire adi_diff_t         pulse_sign,
    input wire logic              pulse_ready
);
    // ****************************************************************
    // Assertions, all in the one clock domain
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_req_in_mode: assert property
        (absolute_position_request |-> absolute_transfer_mode)
        else $error("request seen outside transfer mode");
    a_start_mode: assert property
        (!absolute_transfer_mode && abs_start |=> absolute_transfer_mode)
        else $error("start did not raise transfer mode");
    a_error_ends: assert property
        (abs_error |-> !absolute_transfer_mode && !abs_busy)
        else $error("transfer still busy after timeout");
    // Drive needs settle time before the first request
    a_setup_gap: assert property
        ($rose(absolute_transfer_mode) |-> !absolute_position_request[*8])
        else $error("request too soon after mode on");
    a_req_after_ready: assert property
        ($fell(absolute_position_request) && absolute_transfer_mode
            && !abs_error |-> $past(absolute_data_ready, 2))
        else $error("request dropped without data ready");
    a_done_ends: assert property
        (abs_done |-> ##1 !abs_done ##[0:1] !absolute_transfer_mode)
        else $error("done not followed by mode off");
    a_servo_follow: assert property
        ($rose(servo_on_cmd) |-> ##[1:2] servo_power_on)
        else $error("servo power did not follow command");
    a_hw_step: assert property
        ($changed(positioning_address) && !$past(address_load) |->
            positioning_address == $past(positioning_address) + 32'h1 ||
            positioning_address == $past(positioning_address) - 32'h1)
        else $error("address moved by more than one");
    a_marker_once: assert property
        (zero_marker_event |-> $past(zero_marker_input, 3)
            && !$past(zero_marker_input, 4) ##1 !zero_marker_event)
        else $error("marker event without rising marker");
    a_zero_done: assert property
        (zero_return_done |-> $past(zero_return_active)
            && $past(stopper_method))
        else $error("zero return done outside stopper return");
    a_diff_pairs: assert property
        (pulse_out.pos != pulse_out.neg && pulse_sign.pos != pulse_sign.neg)
        else $error("differential pair not complementary");
    a_pulse_wide: assert property
        ($rose(pulse_out.pos) |-> (pulse_out.pos && !pulse_ready)[*8])
        else $error("output pulse too short");

    c_done: cover property (abs_done);
    c_error: cover property (abs_error);
    c_zero: cover property (zero_return_done);
    c_pulse: cover property ($rose(pulse_out.pos));
endmodule

bind adi_axis_drive adi_axis_monitor #(.ABS_TIMEOUT(ABS_TIMEOUT))
    adi_axis_monitor_inst (.*);

// File: verification/adi_drive_model.sv
// Behavioural model of the servo drive's absolute transfer side
`timescale 1ns/1ps
module adi_drive_model
(
    input wire logic        sys_clk,
    input wire logic        absolute_transfer_mode,
    input wire logic        absolute_position_request,
    input wire logic [31:0] word,
    input wire logic [7:0]  delay,
    input wire logic        mute,
    // Known start levels, so the churn below never sticks at unknown
    output logic            absolute_data_ready = 1'b0,
    output logic            absolute_data_lsb = 1'b0,
    output logic            absolute_data_msb = 1'b1
);
    logic [4:0] step_q;
    logic [7:0] wait_q;
    logic       sent_q;

    // Lines are not valid out of mode, so they churn there
    always @(posedge sys_clk)
    begin
        if (!absolute_transfer_mode)
        begin
            absolute_data_ready <= ~absolute_data_ready;
            absolute_data_lsb <= ~absolute_data_lsb;
            absolute_data_msb <= ~absolute_data_msb;
            step_q <= 5'h00;
            wait_q <= 8'h00;
            sent_q <= 1'b0;
        end
        else if (sent_q)
        begin
            if (!absolute_position_request)
            begin
                absolute_data_ready <= 1'b0;
                absolute_data_lsb <= ~absolute_data_lsb;
                absolute_data_msb <= ~absolute_data_msb;
                step_q <= step_q + 5'h01;
                sent_q <= 1'b0;
            end
        end
        else if (!absolute_position_request || mute)
            absolute_data_ready <= 1'b0;
        else if (wait_q == delay)
        begin
            absolute_data_ready <= 1'b1;
            absolute_data_lsb <= word[2*step_q];
            absolute_data_msb <= word[2*step_q+1];
            sent_q <= 1'b1;
            wait_q <= 8'h00;
        end
        else
            wait_q <= wait_q + 8'h01;
    end
endmodule

// File: verification/tb_top.sv
// Self-checking testbench for the axis drive signal interface
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
    miscompares++; $display("wrong value %s expected %0h seen %0h", \
    nm, ex, gt); end end
module tb_top
    import adi_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0, servo_on_cmd = 1'b0;
    logic absolute_data_ready, absolute_data_lsb, absolute_data_msb;
    logic absolute_transfer_mode, absolute_position_request;
    logic servo_power_on, abs_busy, abs_done, abs_error, pulse_ready;
    logic handwheel_phase_a_neg = 1'b1, handwheel_phase_b_neg = 1'b1;
    logic zero_marker_input = 1'b0, zero_return_active = 1'b0;
    logic stopper_method = 1'b0, abs_start = 1'b0, mute = 1'b0;
    logic handwheel_enable = 1'b0, address_load = 1'b0;
    logic pulse_req = 1'b0, pulse_dir_neg = 1'b0;
    logic zero_marker_event, zero_return_done;
    logic [ADDR_W-1:0] address_load_value = 32'h0000_0000;
    logic [ADDR_W-1:0] positioning_address;
    logic [ABS_WORD_W-1:0] abs_position;
    logic [31:0] word = 32'h0000_0000;
    logic [7:0] delay = 8'h00;
    logic [1:0] hw_idx = 2'h0;
    adi_diff_t pulse_out, pulse_sign;
    int miscompares = 0, checked = 0, cycles = 0, n;

    always #2.5 sys_clk = ~sys_clk;

    adi_axis_drive #(.ABS_TIMEOUT(50)) adi_axis_drive_inst (.*);
    adi_drive_model adi_drive_model_inst (.*);

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Full 16-step read; a second start while busy must be ignored
    task automatic t_abs(input logic [31:0] w, input logic [7:0] d);
        word = w;
        delay = d;
        abs_start = 1'b1;
        @(negedge sys_clk);
        abs_start = 1'b0;
        repeat (2100) @(negedge sys_clk);
        abs_start = 1'b1;
        @(negedge sys_clk);
        abs_start = 1'b0;
        for (n = 0; n < 3000 && abs_done !== 1'b1; n++)
            @(negedge sys_clk);
        repeat (3) @(negedge sys_clk);
        `CHK("abs position", w, abs_position)
        `CHK("mode after done", 1'b0, absolute_transfer_mode)
        repeat (20) @(negedge sys_clk);
        `CHK("stays idle", 1'b0, absolute_transfer_mode)
    endtask

    // Silent drive: timeout, and churn out of mode must not land
    task automatic t_timeout();
        mute = 1'b1;
        abs_start = 1'b1;
        @(negedge sys_clk);
        abs_start = 1'b0;
        for (n = 0; n < 2300 && abs_error !== 1'b1; n++)
            @(negedge sys_clk);
        `CHK("timeout error", 1'b1, abs_error)
        mute = 1'b0;
        repeat (40) @(negedge sys_clk);
        `CHK("mode after error", 1'b0, absolute_transfer_mode)
        `CHK("position kept", 32'h1234_FEDC, abs_position)
    endtask

    task automatic hw_move(input int steps, input bit fwd);
        for (int i = 0; i < steps; i++)
        begin
            hw_idx = fwd ? hw_idx + 2'h1 : hw_idx - 2'h1;
            handwheel_phase_a_neg = ~(hw_idx[1] ^ hw_idx[0]);
            handwheel_phase_b_neg = ~hw_idx[1];
            repeat (4) @(negedge sys_clk);
        end
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic t_handwheel();
        address_load_value = 32'hFFFF_FFFE;
        address_load = 1'b1;
        @(negedge sys_clk);
        address_load = 1'b0;
        hw_move(4, 1'b1);
        `CHK("address disabled", 32'hFFFF_FFFE, positioning_address)
        handwheel_enable = 1'b1;
        hw_move(8, 1'b1);
        `CHK("address forward", 32'h0000_0006, positioning_address)
        hw_move(11, 1'b0);
        `CHK("address back", 32'hFFFF_FFFB, positioning_address)
    endtask

    task automatic t_zero(input logic act, input int exp_done);
        logic [7:0] ev;
        logic [7:0] dn;
        ev = 0;
        dn = 0;
        zero_return_active = act;
        stopper_method = 1'b1;
        zero_marker_input = 1'b1;
        repeat (12)
        begin
            @(negedge sys_clk);
            ev += zero_marker_event;
            dn += zero_return_done;
        end
        zero_marker_input = 1'b0;
        repeat (6) @(negedge sys_clk);
        `CHK("marker events", 1, ev)
        `CHK("zero done", exp_done, dn)
    endtask

    task automatic t_pulse(input logic dir);
        int hi;
        hi = 0;
        `CHK("pulse ready idle", 1'b1, pulse_ready)
        pulse_req = 1'b1;
        pulse_dir_neg = dir;
        @(negedge sys_clk);
        pulse_req = 1'b0;
        for (n = 0; n < 10 && pulse_out.pos !== 1'b1; n++)
            @(negedge sys_clk);
        while (pulse_out.pos === 1'b1 && hi < 400)
        begin
            hi++;
            @(negedge sys_clk);
        end
        `CHK("pulse width", PULSE_WIDTH_CYC, hi)
        `CHK("pulse sign", {dir, ~dir}, pulse_sign)
        repeat (210) @(negedge sys_clk);
        `CHK("pulse ready again", 1'b1, pulse_ready)
    endtask

    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    initial
    begin
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK("mode at reset", 1'b0, absolute_transfer_mode)
        `CHK("pulse at reset", 2'b01, pulse_out)
        servo_on_cmd = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK("servo on", 1'b1, servo_power_on)
        t_abs(32'hA5C3_96E1, 8'h00);
        t_abs(32'h1234_FEDC, 8'h09);
        t_timeout();
        t_handwheel();
        t_zero(1'b0, 0);
        t_zero(1'b1, 1);
        t_pulse(1'b1);
        t_pulse(1'b0);
        servo_on_cmd = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK("servo off", 1'b0, servo_power_on)
        close_out();
    end
endmodule
